/* File: logic/lcc_regs.sv */
// Channel 5 and 6 control registers with their brightness scalers.
// Summary of operation
// - Bits 7..5 pick master fader one, two or three for codes 1, 2, 3.
// - Codes 0, 4, 6, 7 apply no master fading; 0 after reset.
// - Code 5 uses the external PWM dimming level as master fader.
// - Bit 4 turns ratiometric dimming on; off after reset.
// - Ratiometric dimming keeps colour mix regardless of starting level.
// - Bit 3 picks linear (0, default) or exponential (1) brightness law.
// - The brightness law applies under engine and direct PWM control.
// - Bit 2 picks charge pump (0, default) or external LED supply (1).
// - Channel 5 register sits at address 0Ch; reset clears it fully.
// - Channel 6 register sits at 0Dh, same layout, cleared by reset.
`timescale 1ns/10ps
`include "lcc_params.svh"

module lcc_regs #(
   parameter int SAMPLE_CYCLES = `LCC_SAMPLE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic pwm_dim_pin,
   input wire logic [7:0] fader_level_1,
   input wire logic [7:0] fader_level_2,
   input wire logic [7:0] fader_level_3,
   input wire logic engine_owns_ch5,
   input wire logic engine_owns_ch6,
   input wire logic [7:0] engine_level_ch5,
   input wire logic [7:0] engine_level_ch6,
   input wire logic [7:0] direct_level_ch5,
   input wire logic [7:0] direct_level_ch6,
   output logic [2:0] fader_source_sel_ch5,
   output logic [2:0] fader_source_sel_ch6,
   output logic color_ratio_keep_ch5,
   output logic color_ratio_keep_ch6,
   output logic log_curve_sel_ch5,
   output logic log_curve_sel_ch6,
   output logic ext_supply_sel_ch5,
   output logic ext_supply_sel_ch6,
   output logic [7:0] duty_ch5,
   output logic [7:0] duty_ch6,
   output logic charge_pump_req,
   output logic [7:0] pin_level
);

   localparam int NCH = 2;

   lcc_pkg::lcc_byte_t ctrl_ff [NCH];
   logic [7:0] rdata_ff;
   logic [7:0] duty [NCH];
   logic [7:0] eng_lvl [NCH];
   logic [7:0] dir_lvl [NCH];
   logic eng_own [NCH];
   logic [NCH-1:0] hit;
   logic [NCH-1:0] cp_need;
   logic pin_s1_ff;
   logic pin_s2_ff;
   logic pin_s3_ff;
   logic pin_state_ff;
   logic [15:0] tick_cnt_ff;
   logic tick;
   logic [7:0] sample_cnt_ff;
   logic [7:0] high_cnt_ff;
   logic [7:0] pin_level_ff;
   logic [7:0] high_sum;

   // One-hot select of the channel register addressed by the host.
   // Any other address selects nothing, so writes there are dropped and reads return the idle value 00h.
   function automatic logic [NCH-1:0] addr_hit(input logic [7:0] addr);
      logic [NCH-1:0] sel;
      sel = '0;
      if (addr == `LCC_ADDR_CH5) begin
         sel[0] = 1'b1;
      end else if (addr == `LCC_ADDR_CH6) begin
         sel[1] = 1'b1;
      end
      return sel;
   endfunction

   assign hit = addr_hit(reg_addr);

   // Per-channel inputs are gathered into arrays so the generate loop
   // below can index them by channel.
   assign eng_own[0] = engine_owns_ch5;
   assign eng_own[1] = engine_owns_ch6;
   assign eng_lvl[0] = engine_level_ch5;
   assign eng_lvl[1] = engine_level_ch6;
   assign dir_lvl[0] = direct_level_ch5;
   assign dir_lvl[1] = direct_level_ch6;

   // ----------------------------------------------------------------------
   // Control registers and scalers
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < NCH; i++) begin : g_chan
      // All eight bits are stored, the reserved pair included.
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            ctrl_ff[i] <= `LCC_CTRL_RESET;
         end else if (reg_wr && hit[i]) begin
            ctrl_ff[i] <= reg_wdata;
         end
      end

      // One scaler per channel, steered by the stored fields and the engine ownership input.
      lcc_chan_scale u_scale (
         .sys_clk(sys_clk),
         .rst(rst),
         .fade_src(ctrl_ff[i][`LCC_FADE_HI:`LCC_FADE_LO]),
         .ratio_keep(ctrl_ff[i][`LCC_RATIO_BIT]),
         .log_curve(ctrl_ff[i][`LCC_EXP_BIT]),
         .engine_owns(eng_own[i]),
         .engine_level(eng_lvl[i]),
         .direct_level(dir_lvl[i]),
         .fader_1(fader_level_1),
         .fader_2(fader_level_2),
         .fader_3(fader_level_3),
         .pin_level(pin_level_ff),
         .duty_ff(duty[i])
      );

      // A lit channel on the internal supply needs the charge pump.
      assign cp_need[i] = (duty[i] != 8'h00) &&
                          !ctrl_ff[i][`LCC_EXT_BIT];
   end

   // ----------------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------------
   // The read data is registered and holds until the next read strobe,
   // so the host may take it at any time after the answering edge.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= `LCC_RDATA_IDLE;
      end else if (reg_rd && hit[0]) begin
         rdata_ff <= ctrl_ff[0];
      end else if (reg_rd && hit[1]) begin
         rdata_ff <= ctrl_ff[1];
      end else if (reg_rd) begin
         rdata_ff <= `LCC_RDATA_IDLE;
      end
   end

   // ----------------------------------------------------------------------
   // PWM dimming input: synchroniser and duty measurement
   // ----------------------------------------------------------------------
   // The pin is asynchronous; three flops guard against metastability, and
   // a level is taken only once the second and third flops agree, so a
   // single-cycle glitch is filtered out.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
         pin_s3_ff <= 1'b0;
         pin_state_ff <= 1'b0;
      end else begin
         pin_s1_ff <= pwm_dim_pin;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         if (pin_s2_ff == pin_s3_ff) begin
            pin_state_ff <= pin_s3_ff;
         end
      end
   end

   // One sample tick every SAMPLE_CYCLES clocks; the counter is 16 bits
   // wide, so SAMPLE_CYCLES must not exceed 65536.
   assign tick = (tick_cnt_ff == 16'(SAMPLE_CYCLES - 1));

   assign high_sum = high_cnt_ff + {7'h00, pin_state_ff};

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_cnt_ff <= 16'h0000;
      end else if (tick) begin
         tick_cnt_ff <= 16'h0000;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      end
   end

   // The high share of 255 samples gives the master level of the pin.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sample_cnt_ff <= 8'h00;
         high_cnt_ff <= 8'h00;
         pin_level_ff <= 8'h00;
      end else if (tick) begin
         if (sample_cnt_ff == `LCC_SAMPLES_PER_WINDOW - 8'h01) begin
            sample_cnt_ff <= 8'h00;
            high_cnt_ff <= 8'h00;
            pin_level_ff <= high_sum;
         end else begin
            sample_cnt_ff <= sample_cnt_ff + 8'h01;
            high_cnt_ff <= high_sum;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign reg_rdata = rdata_ff;
   assign fader_source_sel_ch5 = ctrl_ff[0][`LCC_FADE_HI:`LCC_FADE_LO];
   assign fader_source_sel_ch6 = ctrl_ff[1][`LCC_FADE_HI:`LCC_FADE_LO];
   assign color_ratio_keep_ch5 = ctrl_ff[0][`LCC_RATIO_BIT];
   assign color_ratio_keep_ch6 = ctrl_ff[1][`LCC_RATIO_BIT];
   assign log_curve_sel_ch5 = ctrl_ff[0][`LCC_EXP_BIT];
   assign log_curve_sel_ch6 = ctrl_ff[1][`LCC_EXP_BIT];
   assign ext_supply_sel_ch5 = ctrl_ff[0][`LCC_EXT_BIT];
   assign ext_supply_sel_ch6 = ctrl_ff[1][`LCC_EXT_BIT];

   // ----------------------------------------------------------------------
   // Scaled duty and status
   // ----------------------------------------------------------------------
   assign duty_ch5 = duty[0];
   assign duty_ch6 = duty[1];
   assign charge_pump_req = |cp_need;
   assign pin_level = pin_level_ff;

endmodule // lcc_regs

/* File: logic/lcc_params.svh */
// Constants for the LED channel control register bank.
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define LCC_ADDR_CH5 8'h0c
`define LCC_ADDR_CH6 8'h0d
`define LCC_CTRL_RESET 8'h00
`define LCC_RDATA_IDLE 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LCC_FADE_HI 7
`define LCC_FADE_LO 5
`define LCC_RATIO_BIT 4
`define LCC_EXP_BIT 3
`define LCC_EXT_BIT 2

// ----------------------------------------------------------------------
// Fader source codes
// ----------------------------------------------------------------------
`define LCC_SRC_FADER1 3'h1
`define LCC_SRC_FADER2 3'h2
`define LCC_SRC_FADER3 3'h3
`define LCC_SRC_PIN 3'h5

// ----------------------------------------------------------------------
// Timing of the PWM dimming input measurement
// ----------------------------------------------------------------------
`define LCC_CLK_PERIOD_NS 50
`define LCC_SAMPLE_NS 39200
`define LCC_SAMPLE_CYCLES (`LCC_SAMPLE_NS / `LCC_CLK_PERIOD_NS)
`define LCC_SAMPLES_PER_WINDOW 8'hff

`endif

/* File: logic/lcc_pkg.sv */
// Types shared by the LED channel control register bank.
`include "lcc_params.svh"

package lcc_pkg;

   typedef logic [7:0] lcc_byte_t;

   typedef enum logic [2:0] {
      LCC_FADE_NONE,
      LCC_FADE_M1,
      LCC_FADE_M2,
      LCC_FADE_M3,
      LCC_FADE_PIN
   } lcc_fade_e;

   // Maps the 3-bit fader source field onto the fading mode.
   function automatic lcc_fade_e decode_fade(input logic [2:0] code);
      lcc_fade_e mode;
      if (code == `LCC_SRC_FADER1) begin
         mode = LCC_FADE_M1;
      end else if (code == `LCC_SRC_FADER2) begin
         mode = LCC_FADE_M2;
      end else if (code == `LCC_SRC_FADER3) begin
         mode = LCC_FADE_M3;
      end else if (code == `LCC_SRC_PIN) begin
         mode = LCC_FADE_PIN;
      end else begin
         mode = LCC_FADE_NONE;
      end
      return mode;
   endfunction

endpackage

/* File: logic/lcc_chan_scale.sv */
// Per-channel brightness scaler steered by one channel control register.
`timescale 1ns/10ps

module lcc_chan_scale (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [2:0] fade_src,
   input wire logic ratio_keep,
   input wire logic log_curve,
   input wire logic engine_owns,
   input wire logic [7:0] engine_level,
   input wire logic [7:0] direct_level,
   input wire logic [7:0] fader_1,
   input wire logic [7:0] fader_2,
   input wire logic [7:0] fader_3,
   input wire logic [7:0] pin_level,
   output logic [7:0] duty_ff
);

   lcc_pkg::lcc_fade_e mode;
   logic [7:0] base;
   logic [7:0] shaped;
   logic [7:0] master;
   logic [12:0] exp_word;
   logic [15:0] product;
   logic [7:0] nxt_duty;

   // ----------------------------------------------------------------------
   // Brightness law, the same for engine and direct control
   // ----------------------------------------------------------------------
   always_comb begin
      base = engine_owns ? engine_level : direct_level;
      exp_word = 13'({1'b1, base[4:0]}) << base[7:5];
      if (!log_curve) begin
         shaped = base;
      end else if (base == 8'h00) begin
         shaped = 8'h00;
      end else begin
         shaped = exp_word[12:5];
      end
   end

   // ----------------------------------------------------------------------
   // Master fading
   // ----------------------------------------------------------------------
   always_comb begin
      mode = lcc_pkg::decode_fade(fade_src);
      case (mode)
         lcc_pkg::LCC_FADE_M1: master = fader_1;
         lcc_pkg::LCC_FADE_M2: master = fader_2;
         lcc_pkg::LCC_FADE_M3: master = fader_3;
         lcc_pkg::LCC_FADE_PIN: master = pin_level;
         default: master = 8'hff;
      endcase
      product = shaped * master;
      if (mode == lcc_pkg::LCC_FADE_NONE) begin
         nxt_duty = shaped;
      end else if (ratio_keep) begin
         // Multiplying keeps the ratio between the channels of one LED.
         nxt_duty = product[15:8];
      end else begin
         nxt_duty = (shaped < master) ? shaped : master;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         duty_ff <= 8'h00;
      end else begin
         duty_ff <= nxt_duty;
      end
   end

endmodule // lcc_chan_scale

/* File: test/lcc_regs_sva.sv */
// Assertion checker for the channel 5 and 6 control register bank.
`timescale 1ns/10ps
`include "lcc_params.svh"

module lcc_regs_sva #(
   parameter int SAMPLE_CYCLES = 784
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] fader_level_1,
   input wire logic [7:0] fader_level_2,
   input wire logic [7:0] fader_level_3,
   input wire logic engine_owns_ch5,
   input wire logic engine_owns_ch6,
   input wire logic [7:0] engine_level_ch5,
   input wire logic [7:0] engine_level_ch6,
   input wire logic [7:0] direct_level_ch5,
   input wire logic [7:0] direct_level_ch6,
   input wire logic [2:0] fader_source_sel_ch5,
   input wire logic [2:0] fader_source_sel_ch6,
   input wire logic color_ratio_keep_ch5,
   input wire logic color_ratio_keep_ch6,
   input wire logic log_curve_sel_ch5,
   input wire logic log_curve_sel_ch6,
   input wire logic ext_supply_sel_ch5,
   input wire logic ext_supply_sel_ch6,
   input wire logic [7:0] duty_ch5,
   input wire logic [7:0] duty_ch6,
   input wire logic charge_pump_req,
   input wire logic [7:0] pin_level
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [5:0] f5, f6;
   logic [7:0] e5, e6;
   assign f5 = {fader_source_sel_ch5, color_ratio_keep_ch5,
      log_curve_sel_ch5, ext_supply_sel_ch5};
   assign f6 = {fader_source_sel_ch6, color_ratio_keep_ch6,
      log_curve_sel_ch6, ext_supply_sel_ch6};

   // Expected duty: shaped level, then master fading by minimum or product.
   function automatic logic [7:0] f_duty(logic [2:0] s, logic r, logic l,
         logic [7:0] b);
      logic [15:0] x;
      logic [7:0] m;
      x = 16'({1'b1, b[4:0]}) << b[7:5];
      if (l && b != 8'h00) b = x[12:5];
      case (s)
         3'h1: m = fader_level_1;
         3'h2: m = fader_level_2;
         3'h3: m = fader_level_3;
         3'h5: m = pin_level;
         default: return b;
      endcase
      x = b * m;
      return r ? x[15:8] : ((b < m) ? b : m);
   endfunction

   always_comb e5 = f_duty(fader_source_sel_ch5, color_ratio_keep_ch5,
      log_curve_sel_ch5,
      engine_owns_ch5 ? engine_level_ch5 : direct_level_ch5);
   always_comb e6 = f_duty(fader_source_sel_ch6, color_ratio_keep_ch6,
      log_curve_sel_ch6,
      engine_owns_ch6 ? engine_level_ch6 : direct_level_ch6);

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   sequence s_wr(a);
      reg_wr && reg_addr == a;
   endsequence
   property p_wr5; s_wr(`LCC_ADDR_CH5) |=> f5 == $past(reg_wdata[7:2]);
   endproperty
   a_wr5: assert property (p_wr5)
      else $error("ch5 fields");
   property p_wr6; s_wr(`LCC_ADDR_CH6) |=> f6 == $past(reg_wdata[7:2]);
   endproperty
   a_wr6: assert property (p_wr6)
      else $error("ch6 fields");
   property p_rd5; reg_rd && !reg_wr && reg_addr == `LCC_ADDR_CH5 |=>
      reg_rdata[7:2] == $past(f5); endproperty
   a_rd5: assert property (p_rd5)
      else $error("ch5 read");
   property p_rdx; reg_rd && reg_addr != `LCC_ADDR_CH5 &&
      reg_addr != `LCC_ADDR_CH6 |=> reg_rdata == `LCC_RDATA_IDLE; endproperty
   a_rdx: assert property (p_rdx)
      else $error("unmapped read");
   property p_rhold; !reg_rd |=> $stable(reg_rdata); endproperty
   a_rhold: assert property (p_rhold)
      else $error("read data moved");
   property p_duty5; !$past(rst) |-> duty_ch5 == $past(e5); endproperty
   a_duty5: assert property (p_duty5)
      else $error("ch5 duty");
   property p_duty6; !$past(rst) |-> duty_ch6 == $past(e6); endproperty
   a_duty6: assert property (p_duty6)
      else $error("ch6 duty");
   property p_pump; charge_pump_req == ((duty_ch5 != 8'h00 &&
      !ext_supply_sel_ch5) || (duty_ch6 != 8'h00 && !ext_supply_sel_ch6));
   endproperty
   a_pump: assert property (p_pump)
      else $error("pump request");
endmodule // lcc_regs_sva

bind lcc_regs lcc_regs_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_sva (.*);

/* File: test/lcc_regs_tb.sv */
// Self-checking bench for the channel 5 and 6 control register bank.
`timescale 1ns/10ps
`include "lcc_params.svh"

module lcc_regs_tb;
   logic sys_clk, rst, reg_wr, reg_rd, pwm_dim_pin, charge_pump_req;
   logic engine_owns_ch5, engine_owns_ch6, color_ratio_keep_ch5;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_level, duty_ch5;
   logic [7:0] duty_ch6, fader_level_1, fader_level_2, fader_level_3;
   logic [7:0] engine_level_ch5, engine_level_ch6, v;
   logic [7:0] direct_level_ch5, direct_level_ch6;
   logic [2:0] fader_source_sel_ch5, fader_source_sel_ch6;
   logic color_ratio_keep_ch6, log_curve_sel_ch5, log_curve_sel_ch6;
   logic ext_supply_sel_ch5, ext_supply_sel_ch6;
   int n_mismatch, comparisons;

   lcc_regs #(.SAMPLE_CYCLES(4)) dut (.*);

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask

   task set_lv(input logic [7:0] x);
      direct_level_ch5 <= x;
      direct_level_ch6 <= ~x;
      engine_level_ch5 <= x ^ 8'h5a;
      engine_level_ch6 <= x + 8'h31;
      fader_level_1 <= x ^ 8'h0f;
      fader_level_2 <= x + 8'h70;
      fader_level_3 <= ~x ^ 8'h81;
      engine_owns_ch5 <= x[0];
      engine_owns_ch6 <= x[1];
   endtask

   task print_verdict;
      $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (8000) @(posedge sys_clk);
      n_mismatch++;
      print_verdict;
   end

   initial begin
      rst <= 1'b1;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= 8'h00;
      reg_wdata <= 8'h00;
      pwm_dim_pin <= 1'b0;
      set_lv(8'h00);
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      rd(`LCC_ADDR_CH5, `LCC_CTRL_RESET);
      rd(`LCC_ADDR_CH6, `LCC_CTRL_RESET);
      // Every fader code on both channels, reserved bits varied too.
      for (int i = 0; i < 8; i++) begin
         v = {i[2:0], i[0], i[1], i[2], i[1:0]};
         set_lv(8'h25 * i[7:0]);
         wr(`LCC_ADDR_CH5, v);
         wr(`LCC_ADDR_CH6, ~v);
         rd(`LCC_ADDR_CH5, v);
         rd(`LCC_ADDR_CH6, ~v);
         repeat (3) @(posedge sys_clk);
      end
      wr(8'h1c, 8'h00);
      rd(8'h1c, `LCC_RDATA_IDLE);
      rd(`LCC_ADDR_CH5, 8'hff);
      pwm_dim_pin <= 1'b1;
      repeat (2200) @(posedge sys_clk);
      #1 chk(pin_level, 8'hff);
      wr(`LCC_ADDR_CH5, 8'hb8);
      wr(`LCC_ADDR_CH6, 8'h5e);
      rd(`LCC_ADDR_CH6, 8'h5e);
      repeat (3) @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(`LCC_ADDR_CH5, `LCC_CTRL_RESET);
      rd(`LCC_ADDR_CH6, `LCC_CTRL_RESET);
      print_verdict;
   end
endmodule // lcc_regs_tb
